// ### rtl/pcsa_pkg.sv
// pcsa_pkg: shared constants, structs and enums for the core address logic
// assumes a single 100 MHz core clock and a wishbone register window
package pcsa_pkg;
   // ==========================================================
   // widths
   localparam int PC_W = 13;
   localparam int DEPTH = 8;
   localparam int SP_W = 3;
   localparam int PAGE_W = 11;
   localparam int HI_W = 5;
   // ==========================================================
   // register word offsets (byte addresses on the wishbone bus)
   localparam logic [3:0] OFS_PCL = 4'h0;
   localparam logic [3:0] OFS_LATCH = 4'h4;
   localparam logic [3:0] OFS_INDIRECT_DATA_PORT = 4'h8;
   localparam logic [3:0] OFS_PTR = 4'hc;
   localparam logic [3:0] OFS_STAT = 4'h0;
   // ==========================================================
   // reset values and field positions
   localparam logic [PC_W-1:0] PC_RST = 13'h0000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [7:0] INDIRECT_DATA_PORT_SELF = 8'h00;
   localparam int PAGE_BIT = 3;
   localparam logic [7:0] DATA_SIZE = 8'h80;
   // ==========================================================
   // core operation codes from the sequencer
   typedef enum logic [2:0] {
      PCSA_OP_NEXT = 3'h0,
      PCSA_OP_CALL = 3'h1,
      PCSA_OP_JUMP = 3'h2,
      PCSA_OP_INTR = 3'h3,
      PCSA_OP_RET = 3'h4,
      PCSA_OP_HOLD = 3'h5
   } pcsa_op_t;
   // bus write strobe bundle
   typedef struct packed {
      logic we;
      logic [3:0] adr;
      logic [7:0] dat;
   } pcsa_wr_t;
   // data memory access request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] adr;
      logic [7:0] dat;
   } pcsa_mem_t;
endpackage : pcsa_pkg

// ### rtl/pcsa_stack.sv
// pcsa_stack: circular return-address stack
// assumes push and pop are never asserted together
`timescale 1ns/1ps
module pcsa_stack
   import pcsa_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // stack operations
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic [PC_W-1:0] push_pc_i,
   output logic [PC_W-1:0] top_o
);
   // ==========================================================
   // storage and pointer
   logic [PC_W-1:0] mem_ff [DEPTH];
   logic [PC_W-1:0] nxt_mem [DEPTH];
   logic [SP_W-1:0] sp_ff;
   logic [SP_W-1:0] nxt_sp;

   // pointer wraps freely, no overflow flag by design
   always_comb
   begin
      nxt_mem = mem_ff;
      nxt_sp = sp_ff;
      if (push_i)
      begin
         nxt_mem[sp_ff] = push_pc_i;
         nxt_sp = sp_ff + 3'h1;
      end
      else if (pop_i)
      begin
         nxt_sp = sp_ff - 3'h1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sp_ff <= 3'h0;
         for (int i = 0; i < DEPTH; i++)
         begin
            mem_ff[i] <= PC_RST;
         end
      end
      else
      begin
         sp_ff <= nxt_sp;
         mem_ff <= nxt_mem;
      end
   end

   // top of stack is the entry below the pointer
   assign top_o = mem_ff[sp_ff - 3'h1];
endmodule : pcsa_stack

// ### rtl/pcsa_indirect.sv
// pcsa_indirect: maps the indirect data port onto the data memory
// assumes the pointer register lives in the top module
`timescale 1ns/1ps
module pcsa_indirect
   import pcsa_pkg::*;
(
   // pointer and access request
   input wire logic [7:0] ptr_i,
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic [7:0] wdat_i,
   // data memory side
   input wire logic [7:0] mem_rdat_i,
   output pcsa_mem_t mem_o,
   output logic [7:0] rdat_o
);
   // ==========================================================
   // redirect; the bank bit is not used so the pointer alone selects
   logic self_sel;
   assign self_sel = (ptr_i == INDIRECT_DATA_PORT_SELF);

   always_comb
   begin
      mem_o.adr = ptr_i;
      mem_o.dat = wdat_i;
      mem_o.rd = rd_i & ~self_sel;
      mem_o.wr = wr_i & ~self_sel;
      rdat_o = self_sel ? 8'h00 : mem_rdat_i;
   end
endmodule : pcsa_indirect

// ### rtl/pcsa_core.sv
// pcsa_core: program counter, paging latch, return stack and indirect port
// assumes the sequencer issues one op per step and data memory reads same cycle
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module pcsa_core
   import pcsa_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // sequencer
   input wire logic step_i,
   input wire pcsa_op_t op_i,
   input wire logic [PAGE_W-1:0] target_i,
   // program fetch
   output logic [PC_W-1:0] fetch_pc_o,
   // data memory
   input wire logic [7:0] mem_rdat_i,
   output pcsa_mem_t mem_o
);
   // ==========================================================
   // state
   logic [PC_W-1:0] pc_ff;
   logic [PC_W-1:0] nxt_pc;
   logic [7:0] latch_ff;
   logic [7:0] nxt_latch;
   logic [7:0] ptr_ff;
   logic [7:0] nxt_ptr;
   logic ack_ff;
   logic nxt_ack;
   logic err_ff;
   logic nxt_err;
   logic [31:0] rdat_ff;
   logic [31:0] nxt_rdat;
   // ==========================================================
   // decode
   logic req;
   logic sel0;
   logic wr_pcl;
   logic ind_rd;
   logic ind_wr;
   logic [7:0] ind_rdat;
   logic push;
   logic pop;
   logic [PC_W-1:0] top;
   logic mapped;
   logic do_step;
   logic wr_latch;
   logic wr_ptr;

   // ==========================================================
   // helpers
   // small pure expressions; every input is an argument so that the
   // continuous assignments below see every change
   // one register word hit by a taken write; only lane 0 carries a byte, so a
   // write with lane 0 off is acked but changes nothing
   function automatic logic wr_hit(input logic take,
                                   input logic we,
                                   input logic lane,
                                   input logic [3:0] adr,
                                   input logic [3:0] ofs);
      return take & we & lane & (adr == ofs);
   endfunction : wr_hit

   // one register word hit by a taken read
   function automatic logic rd_hit(input logic take,
                                   input logic we,
                                   input logic [3:0] adr,
                                   input logic [3:0] ofs);
      return take & ~we & (adr == ofs);
   endfunction : rd_hit

   // the four words sit on word boundaries; any other address is refused
   function automatic logic is_mapped(input logic [3:0] adr);
      return (adr == OFS_PCL) | (adr == OFS_LATCH)
           | (adr == OFS_INDIRECT_DATA_PORT) | (adr == OFS_PTR);
   endfunction : is_mapped

   // a byte register read back in the low lane, upper lanes zero
   function automatic logic [31:0] rd_word(input logic [7:0] b);
      return {24'h000000, b};
   endfunction : rd_word

   // paged branch target: page bits from the latch, in-page bits from the op;
   // software must set the latch over the bus before any branch that leaves the page
   function automatic logic [PC_W-1:0] page_target(input logic [7:0] latch,
                                                   input logic [PAGE_W-1:0] tgt);
      return {latch[HI_W-1:PAGE_BIT+1], latch[PAGE_BIT], tgt};
   endfunction : page_target

   // ==========================================================
   // decode logic
   // new request only when no answer is outstanding, so a request held over
   // the ack cycle is not taken twice
   assign req = wb_cyc_i & wb_stb_i & ~ack_ff & ~err_ff;
   assign sel0 = wb_sel_i[0];
   assign mapped = is_mapped(wb_adr_i);
   assign wr_pcl = wr_hit(req, wb_we_i, sel0, wb_adr_i, OFS_PCL);
   assign wr_latch = wr_hit(req, wb_we_i, sel0, wb_adr_i, OFS_LATCH);
   assign wr_ptr = wr_hit(req, wb_we_i, sel0, wb_adr_i, OFS_PTR);
   assign ind_rd = rd_hit(req, wb_we_i, wb_adr_i, OFS_INDIRECT_DATA_PORT);
   assign ind_wr = wr_hit(req, wb_we_i, sel0, wb_adr_i, OFS_INDIRECT_DATA_PORT);
   // a software low-byte write wins over a same-cycle step, so the step is
   // dropped whole: no push or pop without its counter change
   assign do_step = step_i & ~wr_pcl;
   assign push = do_step & ((op_i == PCSA_OP_CALL) | (op_i == PCSA_OP_INTR));
   assign pop = do_step & (op_i == PCSA_OP_RET);

   // ==========================================================
   // return stack
   // no full or empty flag: a ninth nested call silently overwrites the
   // oldest return address, and a return on an empty stack yields whatever
   // the slot holds; keeping the nesting shallow is up to the software
   pcsa_stack u_stack (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .push_i(push),
      .pop_i(pop),
      .push_pc_i(pc_ff),
      .top_o(top)
   );

   // ==========================================================
   // indirect port
   // the port holds no byte of its own; reads and writes go straight to data
   // memory at the pointer, and a zero pointer turns them into no-ops
   pcsa_indirect u_ind (
      .ptr_i(ptr_ff),
      .rd_i(ind_rd),
      .wr_i(ind_wr),
      .wdat_i(wb_dat_i[7:0]),
      .mem_rdat_i(mem_rdat_i),
      .mem_o(mem_o),
      .rdat_o(ind_rdat)
   );

   // ==========================================================
   // program counter; a software low-byte write beats the sequencer step
   // the counter only changes as a whole word, so the upper five bits are
   // never set from the bus on their own
   always_comb
   begin
      nxt_pc = pc_ff;
      if (wr_pcl)
      begin
         nxt_pc = {latch_ff[HI_W-1:0], wb_dat_i[7:0]};
      end
      else if (do_step)
      begin
         unique case (op_i)
            PCSA_OP_NEXT:
            begin
               nxt_pc = pc_ff + 13'h0001;
            end
            // both branch kinds stay inside the page the latch selects
            PCSA_OP_CALL,
            PCSA_OP_JUMP:
            begin
               nxt_pc = page_target(latch_ff, target_i);
            end
            // the stack takes the old counter in this same cycle
            PCSA_OP_INTR:
            begin
               nxt_pc = 13'h0004;
            end
            // the stacked word is a full address, so no page bit is needed
            PCSA_OP_RET:
            begin
               nxt_pc = top;
            end
            PCSA_OP_HOLD:
            begin
               nxt_pc = pc_ff;
            end
            // codes 6 and 7 are never issued; hold rather than jump anywhere
            default:
            begin
               nxt_pc = pc_ff;
            end
         endcase
      end
   end

   // ==========================================================
   // software registers; stack traffic never touches the latch
   always_comb
   begin
      nxt_latch = latch_ff;
      nxt_ptr = ptr_ff;
      // only the bus writes the latch; calls, returns and interrupts leave it
      // alone, so software must set the page bits before each far branch
      if (wr_latch)
      begin
         nxt_latch = wb_dat_i[7:0];
      end
      // the pointer is a plain byte; no bank bit is kept beside it
      if (wr_ptr)
      begin
         nxt_ptr = wb_dat_i[7:0];
      end
   end

   // ==========================================================
   // bus answer: one cycle after the request, err for unmapped words
   always_comb
   begin
      nxt_ack = req & mapped;
      nxt_err = req & ~mapped;
      nxt_rdat = rdat_ff;
      if (req & ~wb_we_i)
      begin
         unique case (wb_adr_i)
            // the upper counter bits have no read path; only the low byte shows
            OFS_PCL: nxt_rdat = rd_word(pc_ff[7:0]);
            OFS_LATCH: nxt_rdat = rd_word(latch_ff);
            OFS_INDIRECT_DATA_PORT: nxt_rdat = rd_word(ind_rdat);
            OFS_PTR: nxt_rdat = rd_word(ptr_ff);
            default: nxt_rdat = 32'h00000000;
         endcase
      end
   end

   // ==========================================================
   // program counter register; reset starts fetching at the bottom of
   // program memory
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pc_ff <= PC_RST;
      end
      else
      begin
         pc_ff <= nxt_pc;
      end
   end

   // software registers; the pointer leaves reset at zero, so an early
   // indirect access hits the port itself and is harmless
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         latch_ff <= BYTE_RST;
         ptr_ff <= BYTE_RST;
      end
      else
      begin
         latch_ff <= nxt_latch;
         ptr_ff <= nxt_ptr;
      end
   end

   // bus answer registers; ack and err are single-cycle pulses, and the
   // read word holds until the next read replaces it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_ff <= 1'b0;
         err_ff <= 1'b0;
         rdat_ff <= 32'h00000000;
      end
      else
      begin
         ack_ff <= nxt_ack;
         err_ff <= nxt_err;
         rdat_ff <= nxt_rdat;
      end
   end

   // ==========================================================
   // outputs
   // bus and fetch outputs come straight from flip-flops; only the data
   // memory request is combinational, since that memory answers in the
   // same cycle and a register stage would cost a wait state on every read
   assign wb_ack_o = ack_ff;
   assign wb_err_o = err_ff;
   assign wb_dat_o = rdat_ff;
   assign fetch_pc_o = pc_ff;
endmodule : pcsa_core

// ### verification/pcsa_core_asserts.sv
// checker: bus answer timing and sequencer effects on the counter
// assumes it sees only the core's ports, one clock, sync active-high reset
`timescale 1ns/1ps
module pcsa_core_chk
   import pcsa_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   // sequencer and memory
   input wire logic step_i,
   input wire pcsa_op_t op_i,
   input wire logic [PAGE_W-1:0] target_i,
   input wire logic [PC_W-1:0] fetch_pc_o,
   input wire pcsa_mem_t mem_o
);
   // ==========================================================
   // a held request is not retaken while its answer stands
   logic take;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   map_ack_a: assert property (take && wb_adr_i[1:0] == 2'h0 |=> wb_ack_o && !wb_err_o)
      else $error("mapped access not acked");
   unmap_err_a: assert property (take && wb_adr_i[1:0] != 2'h0 |=> wb_err_o && !wb_ack_o)
      else $error("unmapped access not refused");
   pcl_low_a: assert property (take && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_PCL
      |=> fetch_pc_o[7:0] == $past(wb_dat_i[7:0]))
      else $error("counter low byte not written");
   pc_next_a: assert property (step_i && op_i == PCSA_OP_NEXT && !wb_cyc_i
      |=> fetch_pc_o == $past(fetch_pc_o) + 13'h1)
      else $error("counter did not advance");
   jump_page_a: assert property (step_i && op_i == PCSA_OP_JUMP && !wb_cyc_i
      |=> fetch_pc_o[10:0] == $past(target_i))
      else $error("jump target not in page");
   intr_vec_a: assert property (step_i && op_i == PCSA_OP_INTR && !wb_cyc_i
      |=> fetch_pc_o == 13'h004)
      else $error("interrupt vector wrong");
   call_ret_a: assert property (
      (step_i && op_i == PCSA_OP_CALL && !wb_cyc_i) ##1 !step_i
      ##1 (step_i && op_i == PCSA_OP_RET && !wb_cyc_i) |=> fetch_pc_o == $past(fetch_pc_o, 3))
      else $error("return did not restore counter");
   ind_wr_a: assert property (
      mem_o.wr |-> mem_o.adr != 8'h00 && wb_we_i && wb_adr_i == OFS_INDIRECT_DATA_PORT)
      else $error("indirect write to port itself");
   ind_rd_a: assert property (
      mem_o.rd |-> wb_cyc_i && !wb_we_i && wb_adr_i == OFS_INDIRECT_DATA_PORT)
      else $error("stray indirect read");
   ind_fwd_a: assert property (
      take && !wb_we_i && wb_adr_i == OFS_INDIRECT_DATA_PORT && mem_o.adr != 8'h00 |-> mem_o.rd)
      else $error("indirect read not forwarded");
   ind_self_a: assert property (mem_o.adr == 8'h00 |-> !mem_o.rd && !mem_o.wr)
      else $error("port reached itself");
endmodule : pcsa_core_chk
bind pcsa_core pcsa_core_chk chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .step_i(step_i),
   .op_i(op_i), .target_i(target_i), .fetch_pc_o(fetch_pc_o), .mem_o(mem_o));

// ### verification/tb.sv
// tb: drives the core over wishbone and the sequencer port
// assumes data memory content is a fixed function of its address
`timescale 1ns/1ps
module tb
   import pcsa_pkg::*;
;
   // ==========================================================
   // stimulus, responses and bookkeeping
   logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, step = 1'h0;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] dat = 32'h0, rdat;
   logic ack, err;
   pcsa_op_t op = PCSA_OP_HOLD;
   logic [10:0] tgt = 11'h0;
   logic [12:0] pc;
   pcsa_mem_t mem;
   logic [7:0] mrd;
   logic [15:0] q, wmon;
   int mismatches = 0, checked = 0;
   typedef struct {pcsa_op_t o; logic [10:0] t; logic [12:0] e;} pcsa_row_t;
   // op, target, counter after; latch holds 18 and counter starts at 1820
   pcsa_row_t rows[9] = '{'{PCSA_OP_NEXT, 11'h0, 13'h1821}, '{PCSA_OP_CALL, 11'h155, 13'h1955},
      '{PCSA_OP_RET, 11'h0, 13'h1821}, '{PCSA_OP_JUMP, 11'h0aa, 13'h18aa},
      '{PCSA_OP_INTR, 11'h0, 13'h0004}, '{PCSA_OP_CALL, 11'h033, 13'h1833},
      '{PCSA_OP_RET, 11'h0, 13'h0004}, '{PCSA_OP_RET, 11'h0, 13'h18aa},
      '{PCSA_OP_HOLD, 11'h0, 13'h18aa}};
   always #5 clk_i = ~clk_i;
   // memory answers a pattern of the address, so a wrong pointer shows
   assign mrd = mem.adr ^ 8'h5a;
   always @(posedge clk_i) if (mem.wr) wmon <= {mem.adr, mem.dat};
   pcsa_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .wb_err_o(err), .step_i(step), .op_i(op), .target_i(tgt), .fetch_pc_o(pc),
      .mem_rdat_i(mrd), .mem_o(mem));
   // ==========================================================
   // shared tasks
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("[FAIL] %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   // one classic cycle; error answers come back in bit 8 of q
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
      @(posedge clk_i);
      {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, 24'h0, d, s};
      do
         @(posedge clk_i);
      while (!(ack || err));
      q = {7'h0, err, rdat[7:0]};
      {cyc, stb} <= 2'h0;
   endtask : wb
   // isolated sequencer step, counter checked once it has landed
   task automatic run(input pcsa_op_t o, input logic [10:0] t, input logic [12:0] e);
      @(posedge clk_i);
      {step, op, tgt} <= {1'h1, o, t};
      @(posedge clk_i);
      step <= 1'h0;
      @(negedge clk_i);
      chk({3'h0, pc}, {3'h0, e});
   endtask : run
   task automatic close_out;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out
   // ==========================================================
   // watchdog: the whole run needs well under 2000 cycles
   initial
   begin
      #20us;
      mismatches++;
      close_out;
   end
   // main sequence
   initial
   begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'h0;
      @(negedge clk_i);
      chk({3'h0, pc}, 16'h0);
      wb(1'h1, OFS_LATCH, 8'h18, 4'h1);
      wb(1'h1, OFS_PCL, 8'h20, 4'h1);
      @(negedge clk_i);
      chk({3'h0, pc}, 16'h1820);
      foreach (rows[i]) run(rows[i].o, rows[i].t, rows[i].e);
      wb(1'h0, OFS_LATCH, 8'h0, 4'h1);
      chk(q, 16'h18);
      wb(1'h0, OFS_PCL, 8'h0, 4'h1);
      chk(q, 16'haa);
      // nine calls into an eight-deep stack, then eight returns
      wb(1'h1, OFS_LATCH, 8'h0, 4'h1);
      for (int i = 0; i < 9; i++)
      begin
         run(PCSA_OP_JUMP, 11'(i), 13'(i));
         run(PCSA_OP_CALL, 11'h100, 13'h100);
      end
      for (int i = 8; i > 0; i--) run(PCSA_OP_RET, 11'h0, 13'(i));
      // a ninth return finds the first slot, rewritten by the ninth call
      run(PCSA_OP_RET, 11'h0, 13'h0008);
      // indirect port through pointers 5, 6 and then 0
      wb(1'h1, OFS_PTR, 8'h05, 4'h1);
      wb(1'h0, OFS_INDIRECT_DATA_PORT, 8'h0, 4'h1);
      chk(q, 16'h5f);
      wb(1'h1, OFS_PTR, 8'h06, 4'h1);
      wb(1'h0, OFS_INDIRECT_DATA_PORT, 8'h0, 4'h1);
      chk(q, 16'h5c);
      wb(1'h1, OFS_INDIRECT_DATA_PORT, 8'h3c, 4'h1);
      chk(wmon, 16'h063c);
      wb(1'h1, OFS_PTR, 8'h00, 4'h1);
      wb(1'h0, OFS_INDIRECT_DATA_PORT, 8'h0, 4'h1);
      chk(q, 16'h0);
      wb(1'h1, OFS_INDIRECT_DATA_PORT, 8'h77, 4'h1);
      chk(wmon, 16'h063c);
      // a write with lane 0 off and an unmapped address change nothing
      wb(1'h1, OFS_PTR, 8'h09, 4'h0);
      wb(1'h0, OFS_PTR, 8'h0, 4'h1);
      chk(q, 16'h0);
      wb(1'h0, 4'h2, 8'h0, 4'h1);
      chk(q, 16'h100);
      // reset in mid-run: counter, latch and stack all start over
      wb(1'h1, OFS_LATCH, 8'h0b, 4'h1);
      @(posedge clk_i);
      rst_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'h0;
      @(negedge clk_i);
      chk({3'h0, pc}, 16'h0);
      wb(1'h0, OFS_LATCH, 8'h0, 4'h1);
      chk(q, 16'h0);
      run(PCSA_OP_JUMP, 11'h005, 13'h0005);
      run(PCSA_OP_RET, 11'h0, 13'h0000);
      close_out;
   end
endmodule : tb
